// [rtl/fdcfg_pkg.sv]
// Constants for the fast-deceleration configuration register bank
package fdcfg_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] FDCFG_OFFSET = 8'h8c;
  localparam logic [31:0] FDCFG_RESET = 32'h0000_0000;
  localparam logic [31:0] FDCFG_RD_UNMAPPED = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int FDCFG_PARITY_BIT = 31;
  localparam int FDCFG_RSVD_HI = 30;
  localparam int FDCFG_RSVD_LO = 20;
  localparam int FDCFG_BLANK_BIT = 19;
  localparam int FDCFG_WIN_HI = 18;
  localparam int FDCFG_WIN_LO = 16;
  localparam int FDCFG_THR_HI = 15;
  localparam int FDCFG_THR_LO = 13;
  localparam int FDCFG_LOWLIM_HI = 12;
  localparam int FDCFG_LOWLIM_LO = 9;
  localparam int FDCFG_DYN_BIT = 8;
  localparam int FDCFG_EN_BIT = 7;
  localparam int FDCFG_UPLIM_HI = 6;
  localparam int FDCFG_UPLIM_LO = 3;
  localparam int FDCFG_DELTA_HI = 2;
  localparam int FDCFG_DELTA_LO = 0;

  // ----------------------------------------------------------------
  // Code tables, in tenths of a percent, entry 0 in the low slot
  // ----------------------------------------------------------------
  localparam logic [7:0][7:0] FDCFG_WIN_TABLE = {
    8'hfa, 8'hc8, 8'h96, 8'h64, 8'h4b, 8'h32, 8'h19, 8'h00
  };
  localparam logic [7:0][9:0] FDCFG_THR_TABLE = {
    10'h28a, 10'h2bc, 10'h2ee, 10'h320, 10'h352, 10'h384, 10'h3b6, 10'h3e8
  };
  localparam logic [7:0][5:0] FDCFG_DELTA_TABLE = {
    6'h32, 6'h28, 6'h1e, 6'h19, 6'h14, 6'h0f, 6'h0a, 6'h05
  };

  // Current-limit step per code, in millivolts of sense voltage
  localparam logic [10:0] FDCFG_LIM_STEP_MV = 11'h064;
  localparam logic [3:0] FDCFG_LIM_NA_CODE = 4'h0;

endpackage : fdcfg_pkg

// [rtl/fdcfg_regbank.sv]
// Fast-deceleration configuration register with decoded setting outputs
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`timescale 1ns/1ps

module fdcfg_regbank (
  input wire logic core_clk, // 40 MHz core clock
  input wire logic reset, // Asynchronous reset, active high
  input wire logic clk_en, // Freezes all state while low
  input wire logic [7:0] reg_addr, // Register address
  input wire logic reg_wr_en, // Write strobe
  input wire logic [31:0] reg_wr_data, // Write data
  input wire logic reg_rd_en, // Read strobe
  output logic [31:0] reg_rd_data, // Read data, one cycle after strobe
  output logic reg_rd_valid, // Read data valid pulse
  input wire logic decel_in_progress, // Algorithm is in fast deceleration
  output logic quick_slowdown_enable, // Feature enable
  output logic phase_comparator_blank_enable, // Blanking enable field
  output logic phase_comparator_blank, // Blanking active now
  output logic [2:0] decel_duty_window, // Raw window code
  output logic [7:0] duty_window_tenths, // Window, tenths of a percent
  output logic [2:0] decel_duty_threshold, // Raw threshold code
  output logic [9:0] duty_threshold_tenths, // Threshold, tenths of a percent
  output logic [3:0] decel_current_lower_limit, // Raw lower limit code
  output logic [10:0] lower_limit_mv, // Lower limit sense voltage in mV
  output logic lower_limit_valid, // Lower limit code is applicable
  output logic decel_dynamic_current_enable, // Dynamic lowering field
  output logic dynamic_lowering_active, // Lowering armed with feature on
  output logic [3:0] decel_current_upper_limit, // Raw upper limit code
  output logic [10:0] upper_limit_mv, // Upper limit sense voltage in mV
  output logic upper_limit_valid, // Upper limit code is applicable
  output logic [2:0] decel_exit_speed_delta, // Raw exit delta code
  output logic [5:0] exit_delta_tenths, // Exit delta, tenths of a percent
  output logic parity_bit // Stored parity bit
);

  // ----------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------

  // Address match, shared by the write and read paths
  function automatic logic fdcfg_hit(input logic [7:0] addr);
    fdcfg_hit = (addr == fdcfg_pkg::FDCFG_OFFSET);
  endfunction : fdcfg_hit

  // Limit code to millivolts; code 0 stands for not applicable
  // Largest code is 15, so 1500 mV still fits in 11 bits
  function automatic logic [10:0] fdcfg_lim_mv(input logic [3:0] code);
    logic [14:0] prod;
    prod = 15'({11'h000, code} * fdcfg_pkg::FDCFG_LIM_STEP_MV);
    fdcfg_lim_mv = prod[10:0];
  endfunction : fdcfg_lim_mv

  // Limit applicability test, used for both limits
  function automatic logic fdcfg_lim_ok(input logic [3:0] code);
    fdcfg_lim_ok = (code != fdcfg_pkg::FDCFG_LIM_NA_CODE);
  endfunction : fdcfg_lim_ok

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  // Units: duty and speed figures are in tenths of a percent and the
  // limits in millivolts of sense voltage. The current in amps is that
  // voltage over sense_amp_gain, which lives outside this block, so the
  // division is left to the consumer of these outputs.

  // Stored word and read port
  logic [31:0] cfg_reg;
  logic [31:0] cfg_next;
  logic [31:0] rd_data_reg;
  logic [31:0] rd_data_next;
  logic rd_valid_reg;
  logic rd_valid_next;

  // Decoded settings: one flop group per table field, two per limit field, one for blanking
  logic [7:0] win_reg;
  logic [7:0] win_next;
  logic [9:0] thr_reg;
  logic [9:0] thr_next;
  logic [5:0] delta_reg;
  logic [5:0] delta_next;
  logic [10:0] low_mv_reg;
  logic [10:0] low_mv_next;
  logic [10:0] up_mv_reg;
  logic [10:0] up_mv_next;
  logic low_ok_reg;
  logic low_ok_next;
  logic up_ok_reg;
  logic up_ok_next;
  logic blank_reg;
  logic blank_next;

  // ----------------------------------------------------------------
  // Register write and read path
  // ----------------------------------------------------------------

  // Every bit is stored as written, reserved and parity included,
  // so software reads back exactly what it wrote; parity is not checked
  // here because the serial interface owns that scheme.
  //
  // Timing seen by the serial interface: a write lands at the enabled
  // edge that samples it; a read answers one cycle later with a
  // one-cycle valid pulse; unmapped writes are dropped and unmapped
  // reads return zero with valid. clk_en low holds the valid pulse
  // as well, so a reader that gates the clock must qualify it.
  always_comb begin
    cfg_next = cfg_reg;
    rd_data_next = rd_data_reg;
    rd_valid_next = 1'b0;
    if (reg_wr_en && fdcfg_hit(reg_addr)) begin
      cfg_next = reg_wr_data;
    end
    if (reg_rd_en) begin
      rd_valid_next = 1'b1;
      // Read returns the value before a same-cycle write
      rd_data_next = fdcfg_hit(reg_addr) ? cfg_reg : fdcfg_pkg::FDCFG_RD_UNMAPPED;
    end
  end

  // ----------------------------------------------------------------
  // Decoded settings, computed from the next register value so that
  // they line up with the raw fields in the same cycle
  // ----------------------------------------------------------------
  // Tables are indexed by the raw code; entry 0 is the reset choice
  always_comb begin
    win_next = fdcfg_pkg::FDCFG_WIN_TABLE[cfg_next[fdcfg_pkg::FDCFG_WIN_HI:fdcfg_pkg::FDCFG_WIN_LO]];
    thr_next = fdcfg_pkg::FDCFG_THR_TABLE[cfg_next[fdcfg_pkg::FDCFG_THR_HI:fdcfg_pkg::FDCFG_THR_LO]];
    delta_next = fdcfg_pkg::FDCFG_DELTA_TABLE[cfg_next[fdcfg_pkg::FDCFG_DELTA_HI:fdcfg_pkg::FDCFG_DELTA_LO]];
    low_mv_next = fdcfg_lim_mv(cfg_next[fdcfg_pkg::FDCFG_LOWLIM_HI:fdcfg_pkg::FDCFG_LOWLIM_LO]);
    low_ok_next = fdcfg_lim_ok(cfg_next[fdcfg_pkg::FDCFG_LOWLIM_HI:fdcfg_pkg::FDCFG_LOWLIM_LO]);
    up_mv_next = fdcfg_lim_mv(cfg_next[fdcfg_pkg::FDCFG_UPLIM_HI:fdcfg_pkg::FDCFG_UPLIM_LO]);
    up_ok_next = fdcfg_lim_ok(cfg_next[fdcfg_pkg::FDCFG_UPLIM_HI:fdcfg_pkg::FDCFG_UPLIM_LO]);
    // Blanking only matters while the feature is actually decelerating,
    // and it is gated by the feature enable so a stale blank bit cannot
    // mute the comparator while the feature is off
    blank_next = cfg_next[fdcfg_pkg::FDCFG_BLANK_BIT] && cfg_next[fdcfg_pkg::FDCFG_EN_BIT]
                 && decel_in_progress;
  end

  // ----------------------------------------------------------------
  // Registers; clk_en low holds everything
  // ----------------------------------------------------------------

  // Stored word and read port
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      cfg_reg <= fdcfg_pkg::FDCFG_RESET;
      rd_data_reg <= fdcfg_pkg::FDCFG_RESET;
      rd_valid_reg <= 1'b0;
    end else if (clk_en) begin
      cfg_reg <= cfg_next;
      rd_data_reg <= rd_data_next;
      rd_valid_reg <= rd_valid_next;
    end
  end

  // Decoded settings; reset values are the entries for code 0, which
  // match the cleared word so nothing jumps as reset lets go
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      win_reg <= fdcfg_pkg::FDCFG_WIN_TABLE[0];
      thr_reg <= fdcfg_pkg::FDCFG_THR_TABLE[0];
      delta_reg <= fdcfg_pkg::FDCFG_DELTA_TABLE[0];
      low_mv_reg <= 11'h000;
      up_mv_reg <= 11'h000;
      low_ok_reg <= 1'b0;
      up_ok_reg <= 1'b0;
      blank_reg <= 1'b0;
    end else if (clk_en) begin
      win_reg <= win_next;
      thr_reg <= thr_next;
      delta_reg <= delta_next;
      low_mv_reg <= low_mv_next;
      up_mv_reg <= up_mv_next;
      low_ok_reg <= low_ok_next;
      up_ok_reg <= up_ok_next;
      blank_reg <= blank_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all straight from flip-flops except dynamic_lowering_active, an AND of two stored bits
  // ----------------------------------------------------------------

  // Raw fields
  // Parity is only stored; the serial interface makes and checks it
  assign parity_bit = cfg_reg[fdcfg_pkg::FDCFG_PARITY_BIT];
  assign phase_comparator_blank_enable = cfg_reg[fdcfg_pkg::FDCFG_BLANK_BIT];
  assign decel_duty_window = cfg_reg[fdcfg_pkg::FDCFG_WIN_HI:fdcfg_pkg::FDCFG_WIN_LO];
  assign decel_duty_threshold = cfg_reg[fdcfg_pkg::FDCFG_THR_HI:fdcfg_pkg::FDCFG_THR_LO];
  assign decel_current_lower_limit = cfg_reg[fdcfg_pkg::FDCFG_LOWLIM_HI:fdcfg_pkg::FDCFG_LOWLIM_LO];
  assign decel_dynamic_current_enable = cfg_reg[fdcfg_pkg::FDCFG_DYN_BIT];
  assign quick_slowdown_enable = cfg_reg[fdcfg_pkg::FDCFG_EN_BIT];
  assign decel_current_upper_limit = cfg_reg[fdcfg_pkg::FDCFG_UPLIM_HI:fdcfg_pkg::FDCFG_UPLIM_LO];
  assign decel_exit_speed_delta = cfg_reg[fdcfg_pkg::FDCFG_DELTA_HI:fdcfg_pkg::FDCFG_DELTA_LO];

  // Decoded values load together with the word, so they never lag it
  assign duty_window_tenths = win_reg;
  assign duty_threshold_tenths = thr_reg;
  assign exit_delta_tenths = delta_reg;
  assign lower_limit_mv = low_mv_reg;
  assign lower_limit_valid = low_ok_reg;
  assign upper_limit_mv = up_mv_reg;
  assign upper_limit_valid = up_ok_reg;
  assign phase_comparator_blank = blank_reg;

  // Lowering has no effect unless the feature itself is on
  assign dynamic_lowering_active = cfg_reg[fdcfg_pkg::FDCFG_DYN_BIT] && cfg_reg[fdcfg_pkg::FDCFG_EN_BIT];

  // Read port
  // Data holds between reads, so a slow reader may take it late
  assign reg_rd_data = rd_data_reg;
  assign reg_rd_valid = rd_valid_reg;

endmodule : fdcfg_regbank

// [testbench/fdcfg_monitor.sv]
// Assertion checker for the fast-deceleration configuration register
`timescale 1ns/1ps
module fdcfg_monitor (
  input wire logic core_clk, // Core clock
  input wire logic reset, // Async reset, high
  input wire logic clk_en, // Clock enable
  input wire logic [7:0] reg_addr, // Address
  input wire logic reg_wr_en, // Write strobe
  input wire logic [31:0] reg_wr_data, // Write data
  input wire logic reg_rd_en, // Read strobe
  input wire logic [31:0] reg_rd_data, // Read data
  input wire logic reg_rd_valid, // Read valid
  input wire logic quick_slowdown_enable, // Feature enable
  input wire logic phase_comparator_blank_enable, // Blank enable
  input wire logic phase_comparator_blank, // Blank now
  input wire logic [2:0] decel_duty_window, // Window code
  input wire logic [2:0] decel_duty_threshold, // Threshold code
  input wire logic [10:0] lower_limit_mv, // Lower limit
  input wire logic lower_limit_valid, // Lower applicable
  input wire logic decel_dynamic_current_enable, // Dynamic lowering
  input wire logic [10:0] upper_limit_mv, // Upper limit
  input wire logic upper_limit_valid, // Upper applicable
  input wire logic [2:0] decel_exit_speed_delta // Exit delta code
);
  // ----------------------------------------------------------------
  // Checks, all in the core clock domain
  // ----------------------------------------------------------------
  // Write taken at this edge; other addresses are silently dropped
  wire wr_hit = clk_en && reg_wr_en && reg_addr == 8'h8c;
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  rd_pulse_a: assert property (clk_en && reg_rd_en |=> reg_rd_valid)
    else $error("read strobe gave no valid");
  rd_unmapped_a: assert property (clk_en && reg_rd_en && reg_addr != 8'h8c |=> reg_rd_data == 32'h0)
    else $error("unmapped read not zero");
  blank_wr_a: assert property (wr_hit |=> phase_comparator_blank_enable == $past(reg_wr_data[19]))
    else $error("blank enable not stored");
  window_wr_a: assert property (wr_hit |=> decel_duty_window == $past(reg_wr_data[18:16]))
    else $error("window not stored");
  thresh_wr_a: assert property (wr_hit |=> decel_duty_threshold == $past(reg_wr_data[15:13]))
    else $error("threshold not stored");
  lower_lim_a: assert property (wr_hit |=> lower_limit_mv == $past(reg_wr_data[12:9]) * 11'h064 &&
    lower_limit_valid == ($past(reg_wr_data[12:9]) != 4'h0)) else $error("lower limit wrong");
  dyn_wr_a: assert property (wr_hit |=> decel_dynamic_current_enable == $past(reg_wr_data[8]))
    else $error("dynamic enable not stored");
  feat_wr_a: assert property (wr_hit |=> quick_slowdown_enable == $past(reg_wr_data[7]))
    else $error("feature enable not stored");
  upper_lim_a: assert property (wr_hit |=> upper_limit_mv == $past(reg_wr_data[6:3]) * 11'h064 &&
    upper_limit_valid == ($past(reg_wr_data[6:3]) != 4'h0)) else $error("upper limit wrong");
  delta_wr_a: assert property (wr_hit |=> decel_exit_speed_delta == $past(reg_wr_data[2:0]))
    else $error("exit delta not stored");
  // Main scenarios reached
  cover property (wr_hit ##1 clk_en && reg_rd_en);
  cover property (reg_rd_valid && reg_rd_data != 32'h0);
  cover property (phase_comparator_blank);
endmodule : fdcfg_monitor

bind fdcfg_regbank fdcfg_monitor mon (.*);

// [testbench/fdcfg_regbank_bench.sv]
// Self-checking bench for the fast-deceleration configuration register
`timescale 1ns/1ps
module fdcfg_regbank_bench;
  logic core_clk = 0, reset = 1, clk_en = 1, reg_wr_en = 0, reg_rd_en = 0, decel_in_progress = 0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wr_data = 32'h0, reg_rd_data, shadow = 32'h0, rnd;
  logic reg_rd_valid, quick_slowdown_enable, phase_comparator_blank_enable, phase_comparator_blank, parity_bit;
  logic [2:0] decel_duty_window, decel_duty_threshold, decel_exit_speed_delta;
  logic [7:0] duty_window_tenths;
  logic [9:0] duty_threshold_tenths;
  logic [3:0] decel_current_lower_limit, decel_current_upper_limit;
  logic [10:0] lower_limit_mv, upper_limit_mv;
  logic [5:0] exit_delta_tenths;
  logic lower_limit_valid, upper_limit_valid, decel_dynamic_current_enable, dynamic_lowering_active;
  logic [31:0] exp_q[$];
  int err_count = 0, num_checks = 0, seed = 52;
  int win_t[8] = '{0, 25, 50, 75, 100, 150, 200, 250};
  int dlt_t[8] = '{5, 10, 15, 20, 25, 30, 40, 50};

  fdcfg_regbank dut (.*);

  // ----------------------------------------------------------------
  // Clock, tasks and the read-result watcher
  // ----------------------------------------------------------------
  initial forever #12.5 core_clk = ~core_clk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Model is updated at request time; read before write keeps the old word
  task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    #1;
    if (r && clk_en) exp_q.push_back(a == 8'h8c ? shadow : 32'h0);
    if (w && clk_en && a == 8'h8c) shadow = d;
    {reg_wr_en, reg_rd_en, reg_addr, reg_wr_data} = {w, r, a, d};
  endtask : bus

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : give_verdict

  // Oldest expected word is matched against each valid read, mid-cycle where it has settled
  always @(negedge core_clk) if (reg_rd_valid === 1'b1) begin
    chk(reg_rd_data, exp_q.size() > 0 ? exp_q.pop_front() : 32'hxxxx_xxxx);
  end

  // Hang guard, far beyond the few dozen cycles the tests need
  initial begin
    #50us;
    err_count++;
    give_verdict();
  end

  initial begin
    repeat (4) @(posedge core_clk);
    #1 reset = 0;
    bus(0, 1, 8'h8c, 0);
    bus(0, 0, 0, 0);
    chk(duty_threshold_tenths, 1000);
    chk(exit_delta_tenths, 5);
    chk(upper_limit_valid, 0);
    $display("test reset values done");
    // Every code of every field, random parity and reserved bits
    for (int i = 0; i < 16; i++) begin
      rnd = $random(seed);
      decel_in_progress = rnd[0];
      bus(1, 0, 8'h8c, {rnd[31:20], i[0], i[2:0], i[2:0], i[3:0], i[1], i[2], 4'(15 - i), 3'(7 - i)});
      bus(0, 1, 8'h8c, 0);
      chk(phase_comparator_blank_enable, i[0]);
      chk(duty_window_tenths, win_t[i % 8]);
      chk(duty_threshold_tenths, 1000 - 50 * (i % 8));
      chk(phase_comparator_blank, i[0] & i[2] & rnd[0]);
      chk(parity_bit, rnd[31]);
      chk(decel_current_lower_limit, i);
      chk(lower_limit_mv, 100 * i);
      chk(lower_limit_valid, i != 0);
      chk(decel_dynamic_current_enable, i[1]);
      chk(dynamic_lowering_active, i[1] & i[2]);
      chk(quick_slowdown_enable, i[2]);
      chk(decel_current_upper_limit, 15 - i);
      chk(upper_limit_mv, 100 * (15 - i));
      chk(upper_limit_valid, i != 15);
      chk(exit_delta_tenths, dlt_t[7 - i % 8]);
    end
    $display("test field codes done");
    decel_in_progress = 0;
    // Same-cycle read and write, unmapped and frozen accesses
    bus(1, 1, 8'h8c, 32'h8008_0081);
    bus(1, 0, 8'h8d, 32'hffff_ffff);
    bus(0, 1, 8'h8d, 0);
    bus(0, 0, 0, 0);
    // Valid must fall before the freeze, or it would stand through it
    bus(0, 0, 0, 0);
    clk_en = 0;
    bus(1, 0, 8'h8c, 32'h0);
    bus(0, 0, 0, 0);
    chk(quick_slowdown_enable, 1);
    clk_en = 1;
    bus(0, 1, 8'h8c, 0);
    $display("test refused accesses done");
    // Blanking follows the algorithm's deceleration flag one cycle later
    decel_in_progress = 1;
    bus(0, 0, 0, 0);
    chk(phase_comparator_blank, 1);
    decel_in_progress = 0;
    bus(0, 0, 0, 0);
    chk(phase_comparator_blank, 0);
    // Reset in mid-run clears the word
    reset = 1;
    shadow = 32'h0;
    bus(0, 0, 0, 0);
    reset = 0;
    chk(quick_slowdown_enable, 0);
    bus(0, 1, 8'h8c, 0);
    repeat (3) bus(0, 0, 0, 0);
    chk(exp_q.size(), 0);
    $display("test blanking and reset done");
    give_verdict();
  end
endmodule : fdcfg_regbank_bench
